// >>> hw/hold_interval_timer.v
// Hold interval timer counted in DAC word clocks
`timescale 1ns/10ps
`default_nettype none
`include "range_compressor_defines.vh"

module hold_interval_timer (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [3:0] hold_code_in,
  input wire start_in,
  input wire tick_in,
  output reg expired_out
);

  reg [17:0] remaining;
  reg running;
  reg [17:0] hold_len;

  // ****************************************
  // Code to length
  // ****************************************
  always @* begin
    case (hold_code_in)
      4'h0: hold_len = 18'h00000;
      4'ha: hold_len = `HOLD_CODE_10;
      4'hb: hold_len = `HOLD_CODE_11;
      4'hc: hold_len = `HOLD_CODE_12;
      4'hd: hold_len = `HOLD_CODE_13;
      4'he: hold_len = `HOLD_CODE_14;
      4'hf: hold_len = `HOLD_CODE_15;
      default: hold_len = `HOLD_BASE << (hold_code_in - 4'h1);
    endcase
  end

  // ****************************************
  // Countdown
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      remaining <= 18'h00000;
      running <= 1'b0;
      expired_out <= 1'b0;
    end else if (start_in) begin
      remaining <= hold_len;
      running <= (hold_len != 18'h00000);
      expired_out <= (hold_len == 18'h00000);
    end else if (tick_in && running) begin
      remaining <= remaining - 18'h00001;
      if (remaining == 18'h00001) begin
        running <= 1'b0;
        expired_out <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/playback_range_compressor_ctrl.v
// Playback dynamic range compressor: control registers, level detect, gain law and gain apply
`timescale 1ns/10ps
`default_nettype none
`include "range_compressor_defines.vh"

module playback_range_compressor_ctrl (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  input wire [23:0] sample_in,
  input wire sample_valid_in,
  output reg [23:0] sample_out,
  output reg sample_valid_out,
  output wire [8:0] gain_reduction_out,
  output wire compressing_out
);

  reg enable;
  reg [2:0] threshold_code;
  reg [1:0] hysteresis_code;
  reg [3:0] hold_code;
  reg [3:0] attack_code;
  reg [3:0] decay_code;
  reg [1:0] state;
  reg [`GAIN_W-1:0] gain;
  wire hold_expired;
  reg hold_start;

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      enable <= `RESET_ENABLE;
      threshold_code <= `RESET_THRESHOLD;
      hysteresis_code <= `RESET_HYSTERESIS;
      hold_code <= `RESET_HOLD;
      attack_code <= `RESET_ATTACK;
      decay_code <= `RESET_DECAY;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ADDR_COMPRESSOR_CONTROL_ONE: begin
          enable <= reg_wdata_in[`ENABLE_BIT];
          threshold_code <= reg_wdata_in[`THRESHOLD_MSB:`THRESHOLD_LSB];
          hysteresis_code <= reg_wdata_in[`HYSTERESIS_MSB:`HYSTERESIS_LSB];
        end
        `ADDR_COMPRESSOR_CONTROL_TWO: begin
          hold_code <= reg_wdata_in[`HOLD_MSB:`HOLD_LSB];
        end
        `ADDR_COMPRESSOR_CONTROL_THREE: begin
          attack_code <= reg_wdata_in[`ATTACK_MSB:`ATTACK_LSB];
          decay_code <= reg_wdata_in[`DECAY_MSB:`DECAY_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Reserved bits are not stored and read as zero
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_COMPRESSOR_CONTROL_ONE: reg_rdata_out <= {1'b0, enable, 1'b0, threshold_code, hysteresis_code};
        `ADDR_COMPRESSOR_CONTROL_TWO: reg_rdata_out <= {1'b0, hold_code, 3'h0};
        `ADDR_COMPRESSOR_CONTROL_THREE: reg_rdata_out <= {attack_code, decay_code};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Level detect (dB below full scale, quarter dB)
  // ****************************************
  wire [23:0] mag_raw = sample_in[23] ? (24'h000000 - sample_in) : sample_in;
  wire [22:0] mag = mag_raw[23] ? 23'h7fffff : mag_raw[22:0];
  reg [4:0] msb;
  reg [22:0] norm;
  reg [7:0] below_q3;
  integer i;

  always @* begin
    msb = 5'h00;
    for (i = 0; i < 23; i = i + 1) begin
      if (mag[i]) begin
        msb = i[4:0];
      end
    end
    norm = mag << (`LOG_TOP_BIT - msb);
    below_q3 = {(`LOG_FULL_SCALE - msb), 3'h0} - {5'h00, norm[21:19]};
  end

  wire [9:0] level_q2 = {2'h0, below_q3} + {1'b0, below_q3, 1'b0};
  wire [3:0] thr_index = {1'b0, threshold_code} + 4'h1;
  wire [9:0] threshold_q2 = {3'h0, thr_index, 3'h0} + {4'h0, thr_index, 2'h0};
  wire [9:0] hysteresis_q2 = {6'h00, hysteresis_code, 2'h0};
  wire over = level_q2 < threshold_q2;
  wire released = level_q2 > (threshold_q2 + hysteresis_q2);

  // ****************************************
  // Gain law
  // ****************************************
  wire [`GAIN_W-1:0] attack_step = {{(`GAIN_W-1){1'b0}}, 1'b1} << (`ATTACK_SHIFT_BASE - {1'b0, attack_code});
  wire [`GAIN_W-1:0] decay_step = {{(`GAIN_W-1){1'b0}}, 1'b1} << (`DECAY_SHIFT_BASE - {1'b0, decay_code});
  wire [`GAIN_W:0] gain_up = {1'b0, gain} + {1'b0, attack_step};
  wire [`GAIN_W-1:0] gain_sat = gain_up[`GAIN_W] ? `GAIN_MAX : gain_up[`GAIN_W-1:0];
  wire [`GAIN_W-1:0] gain_down = (gain > decay_step) ? (gain - decay_step) : {`GAIN_W{1'b0}};

  reg [1:0] next_state;
  reg [`GAIN_W-1:0] next_gain;

  always @* begin
    next_state = state;
    next_gain = gain;
    hold_start = 1'b0;
    case (state)
      `ST_ATTACK: begin
        // Gain only grows while the level is above threshold; inside the hysteresis band it is kept
        if (over) begin
          next_gain = gain_sat;
        end
        if (released) begin
          next_state = `ST_HOLD;
          hold_start = 1'b1;
        end
      end
      `ST_HOLD: begin
        if (over) begin
          next_state = `ST_ATTACK;
        end else if (hold_expired) begin
          next_state = `ST_RELEASE;
        end
      end
      `ST_RELEASE: begin
        if (over) begin
          next_state = `ST_ATTACK;
          next_gain = gain_sat;
        end else begin
          next_gain = gain_down;
        end
      end
      default: begin
        next_state = `ST_RELEASE;
      end
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state <= `ST_RELEASE;
      gain <= {`GAIN_W{1'b0}};
    end else if (!enable) begin
      state <= `ST_RELEASE;
      gain <= {`GAIN_W{1'b0}};
    end else if (sample_valid_in) begin
      state <= next_state;
      gain <= next_gain;
    end
  end

  hold_interval_timer u_hold (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .hold_code_in(hold_code),
    .start_in(hold_start && enable && sample_valid_in),
    .tick_in(sample_valid_in),
    .expired_out(hold_expired)
  );

  // ****************************************
  // Gain apply
  // ****************************************
  wire [8:0] gain_q3 = gain[`GAIN_W-1:`GAIN_W-9];
  wire [14:0] octave_prod = gain_q3 * `OCTAVE_PER_DB_Q8;
  wire [3:0] oct_int = octave_prod[14:11];
  wire [2:0] oct_frac = octave_prod[10:8];
  wire signed [23:0] shifted = $signed(sample_in) >>> oct_int;
  wire signed [27:0] frac_prod = shifted * $signed({1'b0, oct_frac});
  wire signed [27:0] frac_corr = frac_prod >>> 4;
  wire [23:0] compressed = shifted - frac_corr[23:0];

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sample_out <= 24'h000000;
      sample_valid_out <= 1'b0;
    end else begin
      sample_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        sample_out <= enable ? compressed : sample_in;
      end
    end
  end

  assign gain_reduction_out = gain_q3;
  assign compressing_out = enable && (state == `ST_ATTACK);

endmodule
`default_nettype wire

// >>> hw/range_compressor_defines.vh
// Register map, field layout, reset values and constants of the playback range compressor
`ifndef RANGE_COMPRESSOR_DEFINES_VH
`define RANGE_COMPRESSOR_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_COMPRESSOR_CONTROL_ONE 8'h44
`define ADDR_COMPRESSOR_CONTROL_TWO 8'h45
`define ADDR_COMPRESSOR_CONTROL_THREE 8'h46

// ****************************************
// Field positions
// ****************************************
`define ENABLE_BIT 6
`define THRESHOLD_MSB 4
`define THRESHOLD_LSB 2
`define HYSTERESIS_MSB 1
`define HYSTERESIS_LSB 0
`define HOLD_MSB 6
`define HOLD_LSB 3
`define ATTACK_MSB 7
`define ATTACK_LSB 4
`define DECAY_MSB 3
`define DECAY_LSB 0

// ****************************************
// Reset values
// ****************************************
`define RESET_ENABLE 1'h0
`define RESET_THRESHOLD 3'h3
`define RESET_HYSTERESIS 2'h3
`define RESET_HOLD 4'h7
`define RESET_ATTACK 4'h0
`define RESET_DECAY 4'h0

// ****************************************
// Gain arithmetic (gain reduction in dB with 21 fractional bits)
// ****************************************
`define GAIN_W 27
`define GAIN_MAX 27'h7ffffff
`define ATTACK_SHIFT_BASE 5'h17
`define DECAY_SHIFT_BASE 5'h0f
`define LOG_FULL_SCALE 5'h17
`define LOG_TOP_BIT 5'h16
`define THRESHOLD_STEP_Q2 7'h0c
`define OCTAVE_PER_DB_Q8 6'h2b

// ****************************************
// Hold lengths in word clocks
// ****************************************
`define HOLD_BASE 18'h00020
`define HOLD_CODE_10 18'h04000
`define HOLD_CODE_11 18'h08000
`define HOLD_CODE_12 18'h10000
`define HOLD_CODE_13 18'h18000
`define HOLD_CODE_14 18'h20000
`define HOLD_CODE_15 18'h28000

// ****************************************
// Compressor states
// ****************************************
`define ST_RELEASE 2'h0
`define ST_ATTACK 2'h1
`define ST_HOLD 2'h2

`endif

// >>> tb/playback_range_compressor_ctrl_assertions.sv
// Port checks for the playback range compressor
`timescale 1ns/10ps
`default_nettype none
module playback_range_compressor_ctrl_assertions (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire sample_valid_in,
  input wire [23:0] sample_out,
  input wire sample_valid_out,
  input wire [8:0] gain_reduction_out,
  input wire compressing_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_valid_follow: assert property (sample_valid_in |=> sample_valid_out) else $error("no valid");
  a_valid_only: assert property (!sample_valid_in |=> !sample_valid_out) else $error("extra valid");
  a_out_hold: assert property (!sample_valid_in |=> $stable(sample_out)) else $error("sample moved");
  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("rdata moved");
  a_gain_steady: assert property (!sample_valid_in && !reg_wr_in && !$past(reg_wr_in) |=> $stable(gain_reduction_out))
    else $error("gain moved");
  a_disable_clear: assert property (reg_wr_in && reg_addr_in == 8'h44 && !reg_wdata_in[6]
    |=> !compressing_out ##1 gain_reduction_out == 9'h000) else $error("not cleared");
  a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < 8'h44 || reg_addr_in > 8'h46)
    |=> reg_rdata_out == 8'h00) else $error("unmapped read");
  a_reserved_one: assert property (reg_rd_in && reg_addr_in == 8'h44
    |=> !reg_rdata_out[7] && !reg_rdata_out[5]) else $error("reserved set");
  a_reserved_two: assert property (reg_rd_in && reg_addr_in == 8'h45
    |=> !reg_rdata_out[7] && reg_rdata_out[2:0] == 3'h0) else $error("reserved set");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |=> !sample_valid_out &&
    reg_rdata_out == 8'h00 && gain_reduction_out == 9'h000 && !compressing_out) else $error("reset");
endmodule
`default_nettype wire

// >>> tb/playback_range_compressor_ctrl_tb.sv
// Self-checking bench for the playback range compressor
`timescale 1ns/10ps
`default_nettype none
module playback_range_compressor_ctrl_tb;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [23:0] sample_in = 24'h000000;
  logic sample_valid_in = 1'b0;
  wire [7:0] reg_rdata_out;
  wire [23:0] sample_out;
  wire sample_valid_out;
  wire [8:0] gain_reduction_out;
  wire compressing_out;
  int bad_count = 0;
  int checked = 0;
  logic [8:0] g0;
  logic [7:0] regs[3] = '{8'h0f, 8'h38, 8'h00};
  logic [7:0] mask[3] = '{8'h5f, 8'h78, 8'hff};
  playback_range_compressor_ctrl i_dut (.clk_sys_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .sample_in, .sample_valid_in, .sample_out, .sample_valid_out,
    .gain_reduction_out, .compressing_out);
  initial forever #10 clk_sys_in = ~clk_sys_in;
  // Sample amplitude for a level given in dB below full scale
  function automatic logic [23:0] amp(input real db);
    return 24'(int'(8388607.0 * 10.0 ** (-db / 20.0)));
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
    if (a >= 8'h44 && a <= 8'h46) regs[a - 8'h44] = d & mask[a - 8'h44];
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_in = 1'b0;
    chk(reg_rdata_out, (a >= 8'h44 && a <= 8'h46) ? regs[a - 8'h44] : 8'h00);
  endtask
  task automatic smp(input logic [23:0] v, input bit pass);
    @(negedge clk_sys_in);
    sample_in = v;
    sample_valid_in = 1'b1;
    @(negedge clk_sys_in);
    sample_valid_in = 1'b0;
    chk(sample_valid_out, 1'b1);
    if (pass) chk(sample_out, v);
  endtask
  task automatic conclude;
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk_sys_in);
    bad_count++;
    conclude;
  end
  initial begin
    void'($urandom(32'h01101465));
    repeat (3) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    for (int a = 0; a < 4; a++) rd(8'h44 + a[7:0]);
    repeat (20) smp(24'($urandom), 1'b1);
    for (int a = 0; a < 4; a++) begin
      wr(8'h44 + a[7:0], a < 3 ? mask[a] : 8'hff);
      rd(8'h44 + a[7:0]);
    end
    wr(8'h46, 8'($urandom));
    rd(8'h46);
    for (int c = 0; c < 16; c++) begin
      wr(8'h45, c[7:0] << 3);
      rd(8'h45);
    end
    wr(8'h46, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h44, 8'h00);
      wr(8'h44, 8'h40 | (c[7:0] << 2) | (c[7:0] & 8'h03));
      repeat (3) smp(amp(3.0 * c + 4.5), 1'b0);
      chk(compressing_out, 1'b0);
      chk(gain_reduction_out, 9'h000);
      repeat (2) smp(amp(3.0 * c), 1'b0);
      chk(compressing_out, 1'b1);
      if (c % 4 >= 2) begin
        smp(amp(3.0 * c + 1.5 + c % 4), 1'b0);
        chk(compressing_out, 1'b1);
      end
      smp(amp(3.0 * c + 4.5 + c % 4), 1'b0);
      chk(compressing_out, 1'b0);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h44, 8'h00);
      wr(8'h46, c[7:0] << 4);
      wr(8'h44, 8'h40);
      repeat (2) smp(24'h7fffff, 1'b0);
      g0 = gain_reduction_out;
      smp(24'h7fffff, 1'b0);
      chk(gain_reduction_out - g0, 9'h020 >> c);
      chk(sample_out < 24'h7fffff, 1'b1);
    end
    for (int d = 0; d < 3; d++) begin
      wr(8'h44, 8'h00);
      wr(8'h45, d == 0 ? 8'h00 : 8'h08);
      wr(8'h46, 8'h30 | (d[7:0] >> 1));
      wr(8'h44, 8'h40);
      repeat (8) smp(24'h7fffff, 1'b0);
      repeat (2) smp(24'h000010, 1'b0);
      chk(compressing_out, 1'b0);
      g0 = gain_reduction_out;
      repeat (d == 0 ? 0 : 29) begin
        smp(24'h000010, 1'b0);
        chk(gain_reduction_out, g0);
      end
      repeat (8) smp(24'h000010, 1'b0);
      g0 = gain_reduction_out;
      repeat (64) smp(24'h000010, 1'b0);
      chk(g0 - gain_reduction_out, 9'h008 >> (d >> 1));
    end
    wr(8'h44, 8'h0f);
    @(negedge clk_sys_in);
    chk(gain_reduction_out, 9'h000);
    repeat (4) smp(24'($urandom), 1'b1);
    conclude;
  end
endmodule
bind playback_range_compressor_ctrl playback_range_compressor_ctrl_assertions i_chk (.clk_sys_in, .resetn_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .sample_valid_in, .sample_out,
  .sample_valid_out, .gain_reduction_out, .compressing_out);
`default_nettype wire
